// *** cap_sense_trigger_accum_ctrl.v ***
// Capacitive sense start-of-conversion, accumulation and interrupt gating
`timescale 1ns/100ps
`default_nettype none
`include "cap_sense_defs.vh"
module cap_sense_trigger_accum_ctrl (
   input wire clk,
   input wire rst_b,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata,
   input wire t0_ovf,
   input wire t1_ovf,
   input wire t2_ovf,
   input wire t3_ovf,
   input wire sample_done,
   input wire compare_hit,
   output reg sample_start,
   output reg conv_active,
   output reg ground_others_en,
   output reg auto_scan_en,
   output reg compare_irq,
   output reg done_irq
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_START = 2'b01;
   localparam [1:0] ST_WAIT = 2'b10;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] cap_sense_config;
   reg [7:0] extended_irq_enable_two;
   reg unit_enable;
   reg conv_busy_bit;
   reg conv_done_flag;
   reg threshold_compare_flag;
   reg cont_run;
   reg next_start;
   reg next_clear;
   reg next_finish;
   wire timer_trig;
   wire last_sample;
   wire [2:0] start_trigger_select;
   wire [2:0] accum_count_select;
   wire wr_cfg;
   wire wr_ien;
   wire wr_ctl;
   wire busy_write;
   wire cont_mode;
   wire start_req;

   assign start_trigger_select = cap_sense_config[`CS_MODE_HI:`CS_MODE_LO];
   assign accum_count_select = cap_sense_config[`CS_ACC_HI:`CS_ACC_LO];
   assign wr_cfg = sfr_wr && (sfr_addr == `CS_CFG_ADDR);
   assign wr_ien = sfr_wr && (sfr_addr == `CS_IEN_ADDR);
   assign wr_ctl = sfr_wr && (sfr_addr == `CS_CTL_ADDR);
   assign busy_write = wr_ctl && sfr_wdata[`CS_CTL_BUSY];
   assign cont_mode = (start_trigger_select == `CS_MODE_CONT) ||
                      (start_trigger_select == `CS_MODE_SCAN);

   // Only the idle state listens, so late triggers are simply dropped
   assign start_req = unit_enable && (
      (busy_write && (start_trigger_select == `CS_MODE_SW)) ||
      timer_trig ||
      (cont_run && cont_mode));

   cs_trigger_select u_trig (
      .clk(clk),
      .rst_b(rst_b),
      .mode(start_trigger_select),
      .t0_ovf(t0_ovf),
      .t1_ovf(t1_ovf),
      .t2_ovf(t2_ovf),
      .t3_ovf(t3_ovf),
      .timer_trig(timer_trig)
   );

   cs_sample_counter u_count (
      .clk(clk),
      .rst_b(rst_b),
      .clear(next_clear),
      .step(state == ST_WAIT && sample_done),
      .accum_code(accum_count_select),
      .last(last_sample)
   );

   // Sequencer
   always @* begin
      next_state = state;
      next_start = 1'b0;
      next_clear = 1'b0;
      next_finish = 1'b0;
      case (state)
         ST_IDLE: begin
            if (start_req) begin
               next_state = ST_START;
               next_start = 1'b1;
               next_clear = 1'b1;
            end
         end
         ST_START: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (sample_done) begin
               if (last_sample) begin
                  next_state = ST_IDLE;
                  next_finish = 1'b1;
               end else begin
                  next_state = ST_START;
                  next_start = 1'b1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         sample_start <= 1'b0;
         conv_active <= 1'b0;
         ground_others_en <= 1'b0;
      end else begin
         state <= next_state;
         sample_start <= next_start;
         conv_active <= (next_state != ST_IDLE);
         ground_others_en <= (next_state != ST_IDLE);
      end
   end

   // Registers reached over the special function register port
   always @(posedge clk) begin
      if (!rst_b) begin
         cap_sense_config <= `CS_CFG_RESET;
         extended_irq_enable_two <= `CS_IEN_RESET;
         unit_enable <= 1'b0;
      end else begin
         if (wr_cfg) begin
            cap_sense_config <= sfr_wdata & `CS_CFG_MASK;
         end
         if (wr_ien) begin
            extended_irq_enable_two <= sfr_wdata & `CS_IEN_MASK;
         end
         if (wr_ctl) begin
            unit_enable <= sfr_wdata[`CS_CTL_ENABLE];
         end
      end
   end

   // Continuous run latch; stops on a busy write of 0, a non-continuous mode or the unit disabled
   always @(posedge clk) begin
      if (!rst_b) begin
         cont_run <= 1'b0;
      end else if (busy_write && cont_mode) begin
         cont_run <= 1'b1;
      end else if ((wr_ctl && !sfr_wdata[`CS_CTL_BUSY]) || !cont_mode || !unit_enable) begin
         cont_run <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         auto_scan_en <= 1'b0;
      end else begin
         auto_scan_en <= cont_run && (start_trigger_select == `CS_MODE_SCAN);
      end
   end

   // Busy shows a conversion in flight or a continuous run armed
   always @(posedge clk) begin
      if (!rst_b) begin
         conv_busy_bit <= 1'b0;
      end else begin
         conv_busy_bit <= (next_state != ST_IDLE) || (cont_run && cont_mode);
      end
   end

   // Set beats a software clear in the same cycle
   always @(posedge clk) begin
      if (!rst_b) begin
         conv_done_flag <= 1'b0;
         threshold_compare_flag <= 1'b0;
      end else begin
         if (next_finish) begin
            conv_done_flag <= 1'b1;
         end else if (wr_ctl && !sfr_wdata[`CS_CTL_DONE]) begin
            conv_done_flag <= 1'b0;
         end
         if (compare_hit) begin
            threshold_compare_flag <= 1'b1;
         end else if (wr_ctl && !sfr_wdata[`CS_CTL_CMP]) begin
            threshold_compare_flag <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         compare_irq <= 1'b0;
         done_irq <= 1'b0;
      end else begin
         compare_irq <= threshold_compare_flag && extended_irq_enable_two[`CS_IEN_CMP];
         done_irq <= conv_done_flag && extended_irq_enable_two[`CS_IEN_DONE];
      end
   end

   // Read data registered; unmapped addresses read zero
   always @(posedge clk) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `CS_CFG_ADDR: sfr_rdata <= cap_sense_config & `CS_CFG_MASK;
            `CS_IEN_ADDR: sfr_rdata <= extended_irq_enable_two & `CS_IEN_MASK;
            `CS_CTL_ADDR: sfr_rdata <= {unit_enable, 1'b0, conv_done_flag, conv_busy_bit,
                                        threshold_compare_flag, 3'b000};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule // cap_sense_trigger_accum_ctrl
`default_nettype wire

// *** cap_sense_defs.vh ***
// Constants for the capacitive sense trigger and accumulation control
`ifndef CAP_SENSE_DEFS_VH
`define CAP_SENSE_DEFS_VH

`define CS_CFG_ADDR 8'h9E
`define CS_IEN_ADDR 8'hE7
`define CS_CTL_ADDR 8'hB0

`define CS_CFG_RESET 8'h00
`define CS_IEN_RESET 8'h00
`define CS_CFG_MASK 8'h77
`define CS_IEN_MASK 8'h03

`define CS_MODE_HI 6
`define CS_MODE_LO 4
`define CS_ACC_HI 2
`define CS_ACC_LO 0

`define CS_CTL_ENABLE 7
`define CS_CTL_DONE 5
`define CS_CTL_BUSY 4
`define CS_CTL_CMP 3

`define CS_IEN_CMP 1
`define CS_IEN_DONE 0

`define CS_MODE_SW 3'h0
`define CS_MODE_T0 3'h1
`define CS_MODE_T2 3'h2
`define CS_MODE_T1 3'h3
`define CS_MODE_T3 3'h4
`define CS_MODE_RSVD 3'h5
`define CS_MODE_CONT 3'h6
`define CS_MODE_SCAN 3'h7

`define CS_ACC_1 3'h0
`define CS_ACC_4 3'h1
`define CS_ACC_8 3'h2
`define CS_ACC_16 3'h3
`define CS_ACC_32 3'h4
`define CS_ACC_64 3'h5

`endif

// *** cs_trigger_select.v ***
// Timer overflow trigger selection for the capacitive sense unit
`timescale 1ns/100ps
`default_nettype none
`include "cap_sense_defs.vh"
module cs_trigger_select (
   input wire clk,
   input wire rst_b,
   input wire [2:0] mode,
   input wire t0_ovf,
   input wire t1_ovf,
   input wire t2_ovf,
   input wire t3_ovf,
   output reg timer_trig
);
   reg next_trig;

   always @* begin
      case (mode)
         `CS_MODE_T0: next_trig = t0_ovf;
         `CS_MODE_T2: next_trig = t2_ovf;
         `CS_MODE_T1: next_trig = t1_ovf;
         `CS_MODE_T3: next_trig = t3_ovf;
         default: next_trig = 1'b0;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         timer_trig <= 1'b0;
      end else begin
         timer_trig <= next_trig;
      end
   end
endmodule // cs_trigger_select
`default_nettype wire

// *** cs_sample_counter.v ***
// Sample counter that marks the last sample of one accumulated result
`timescale 1ns/100ps
`default_nettype none
`include "cap_sense_defs.vh"
module cs_sample_counter (
   input wire clk,
   input wire rst_b,
   input wire clear,
   input wire step,
   input wire [2:0] accum_code,
   output wire last
);
   reg [6:0] count;

   // Reserved codes fall back to a single sample
   function [6:0] samples_for;
      input [2:0] code;
      begin
         case (code)
            `CS_ACC_4: samples_for = 7'h04;
            `CS_ACC_8: samples_for = 7'h08;
            `CS_ACC_16: samples_for = 7'h10;
            `CS_ACC_32: samples_for = 7'h20;
            `CS_ACC_64: samples_for = 7'h40;
            default: samples_for = 7'h01;
         endcase
      end
   endfunction

   assign last = (count == samples_for(accum_code) - 7'h01);

   always @(posedge clk) begin
      if (!rst_b) begin
         count <= 7'h00;
      end else if (clear) begin
         count <= 7'h00;
      end else if (step) begin
         count <= count + 7'h01;
      end
   end
endmodule // cs_sample_counter
`default_nettype wire

// *** cs_ctrl_properties.sv ***
// Port-level checks for the capacitive sense trigger control
`timescale 1ns/100ps
`default_nettype none
module cs_ctrl_props (
   input wire clk,
   input wire rst_b,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata,
   input wire sample_done,
   input wire sample_start,
   input wire conv_active,
   input wire ground_others_en,
   input wire compare_irq,
   input wire done_irq
);
   reg [1:0] ien;
   reg [2:0] mode;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadows of the written fields, kept from bus writes only
   always @(posedge clk) begin
      if (!rst_b) begin
         ien <= 2'h0;
         mode <= 3'h0;
      end else if (sfr_wr) begin
         if (sfr_addr == 8'hE7) ien <= sfr_wdata[1:0];
         if (sfr_addr == 8'h9E) mode <= sfr_wdata[6:4];
      end
   end
   // Four samples span the pulse edge and the registered start
   sequence s_rsvd; (mode == 3'h5) [*4]; endsequence
   property p_gnd; ground_others_en == conv_active; endproperty
   property p_one; sample_start |-> conv_active ##1 !sample_start; endproperty
   property p_rsvd; s_rsvd |-> !$rose(conv_active); endproperty
   property p_end; $fell(conv_active) |-> $past(sample_done); endproperty
   property p_cmp; compare_irq |-> $past(ien[1]); endproperty
   property p_done; done_irq |-> $past(ien[0]); endproperty
   property p_cfg;
      sfr_rd && sfr_addr == 8'h9E |=> sfr_rdata == {1'b0, $past(mode), 4'h0} ||
         sfr_rdata[7] == 1'b0 && sfr_rdata[3] == 1'b0 && sfr_rdata[6:4] == $past(mode);
   endproperty
   property p_ien; sfr_rd && sfr_addr == 8'hE7 |=> sfr_rdata == {6'h00, $past(ien)}; endproperty
   a_gnd: assert property (p_gnd) else $error("ground differs");
   a_one: assert property (p_one) else $error("bad start pulse");
   a_rsvd: assert property (p_rsvd) else $error("reserved start");
   a_end: assert property (p_end) else $error("early end");
   a_cmp: assert property (p_cmp) else $error("compare unmasked");
   a_done: assert property (p_done) else $error("done unmasked");
   a_cfg: assert property (p_cfg) else $error("config read");
   a_ien: assert property (p_ien) else $error("enable read");
endmodule // cs_ctrl_props
bind cap_sense_trigger_accum_ctrl cs_ctrl_props u_props (.*);
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the capacitive sense trigger control
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, sd = 0, hit = 0;
   logic [7:0] addr = 0, wd = 0;
   logic [3:0] tov = 0;
   wire [7:0] rdata;
   wire st, act, gnd, scan, c_irq, d_irq;
   int n_errors = 0, checked = 0, n, m, i;
   cap_sense_trigger_accum_ctrl dut (.clk(clk), .rst_b(rst_b), .sfr_addr(addr),
      .sfr_wdata(wd), .sfr_wr(wr_s), .sfr_rd(rd_s), .sfr_rdata(rdata),
      .t0_ovf(tov[0]), .t1_ovf(tov[1]), .t2_ovf(tov[2]), .t3_ovf(tov[3]),
      .sample_done(sd), .compare_hit(hit), .sample_start(st), .conv_active(act),
      .ground_others_en(gnd), .auto_scan_en(scan), .compare_irq(c_irq), .done_irq(d_irq));
   initial forever #50 clk = ~clk;
   // Model: samples per result, 11x treated as one
   function logic [7:0] nsamp(int c);
      return (c == 0 || c > 5) ? 8'h01 : 8'h02 << c;
   endfunction
   function int tsel(int md);
      return md == 1 ? 0 : md == 2 ? 2 : md == 3 ? 1 : md == 4 ? 3 : -1;
   endfunction
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #10;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr_s = 1;
      tick(1);
      wr_s = 0;
      // Idle cycle so a following write never re-raises the strobe at once
      tick(1);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      rd_s = 1;
      tick(1);
      rd_s = 0;
      tick(1);
      chk(rdata, e);
   endtask
   // Answers every sample; after stop starts, writes the stop
   task conv(input int stop, input logic sc, output int cnt);
      int idle, k;
      cnt = 0;
      idle = 0;
      // A busy write start may already be in its wait state on entry
      for (k = 0; k < 3000 && idle < 6; k++) begin
         if (st === 1'b1 || (k == 0 && act === 1'b1)) begin
            cnt++;
            idle = 0;
            chk(gnd, 1'b1);
            chk(scan, sc);
            if (cnt == stop) wr(8'hB0, 8'h80);
            tick(1 + $urandom % 3);
            sd = 1;
            tick(1);
            sd = 0;
         end else begin
            idle = (act === 1'b1) ? 0 : idle + 1;
            tick(1);
         end
      end
   endtask
   task end_of_test;
      $display("Counts: %0d checks, %0d errors", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #2_000_000;
      n_errors++;
      end_of_test;
   end
   initial begin
      void'($urandom(9308));
      tick(8);
      rst_b = 1;
      rd(8'h9E, 8'h00);
      rd(8'hE7, 8'h00);
      wr(8'h9E, 8'hFF);
      rd(8'h9E, 8'h77);
      wr(8'hE7, 8'hFF);
      rd(8'hE7, 8'h03);
      rd(8'h55, 8'h00);
      $display("registers done");
      wr(8'hE7, 8'h01);
      wr(8'hB0, 8'h80);
      for (m = 0; m < 8; m++) begin
         wr(8'h9E, m[7:0]);
         wr(8'hB0, 8'h90);
         conv(0, 1'b0, n);
         chk(n[7:0], nsamp(m));
         chk(d_irq, 1'b1);
         wr(8'hB0, 8'h80);
         tick(2);
         chk(d_irq, 1'b0);
      end
      $display("accumulation done");
      for (m = 1; m < 6; m++)
         for (i = 0; i < 4; i++) begin
            wr(8'h9E, {1'b0, m[2:0], 4'h0});
            tov[i] = 1;
            tick(1);
            tov = 0;
            conv(0, 1'b0, n);
            chk(n[7:0], tsel(m) == i);
         end
      $display("timers done");
      for (m = 6; m < 8; m++) begin
         wr(8'h9E, {1'b0, m[2:0], 4'h0});
         wr(8'hB0, 8'h90);
         conv(3, m == 7, n);
         chk(n[7:0], 8'h03);
      end
      wr(8'hE7, 8'h02);
      hit = 1;
      tick(1);
      hit = 0;
      tick(2);
      chk(c_irq, 1'b1);
      chk(d_irq, 1'b0);
      wr(8'hE7, 8'h00);
      tick(2);
      chk(c_irq, 1'b0);
      $display("continuous and interrupts done");
      end_of_test;
   end
endmodule // testbench
`default_nettype wire
